// ---- adc_power_mode_sequencer.sv ----
// holds the power-mode sequencer: shutdown, init, sleep, wake, active, ramp-down
// assumes register writes arrive pre-decoded from the control port on clk_i
`timescale 1ns/100ps
// How it works
// - pin low holds hardware shutdown
// - 1 ms register init, then sleep
// - active configured clocked device streams tdm
// - sleep request ramps down over 6 ms
// - sleep keeps every register value
// - sleep and wake repeat indefinitely
// - pin low anytime forces shutdown
module adc_power_mode_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int INIT_CYC = INIT_WAIT_CYC,
  parameter int WAKE_CYC = WAKE_WAIT_CYC,
  parameter int RAMP_CYC = SLEEP_RAMP_CYC
) (
  input wire logic clk_i, // system clock 200 MHz
  input wire logic rstn_i, // async reset, active low
  input wire logic hw_shutdown_pin_n_i, // shutdown pin, active low, async
  input wire logic bit_clk_i, // link bit clock, async
  input wire logic frame_sync_i, // frame sync, async
  input wire reg_wr_s reg_wr_i, // decoded register write
  input wire logic [7:0] rd_idx_i, // register read index
  input wire logic [SLOTS*WORD_BITS-1:0] samples_i, // recorded channel samples
  output logic [7:0] rd_data_o, // register read data
  output logic sdout_o, // tdm serial data
  output pwr_state_e state_o, // current power mode
  output logic sleep_status_o, // status bit 7: asleep
  output logic mic_bias_en_o, // mic bias supply enable
  output logic internal_regulator_o // internal regulator select
);

  // ==========================================================================
  // input synchronisers
  logic [2:0] shdn_sync_r;
  logic [2:0] bclk_sync_r;
  logic [2:0] fs_sync_r;
  logic shdn_n_r;
  logic bclk_r;
  logic fs_r;

  function automatic logic filt(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction : filt

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shdn_sync_r <= 3'h0;
      bclk_sync_r <= 3'h0;
      fs_sync_r <= 3'h0;
      shdn_n_r <= 1'b0;
      bclk_r <= 1'b0;
      fs_r <= 1'b0;
    end else begin
      shdn_sync_r <= {shdn_sync_r[1:0], hw_shutdown_pin_n_i};
      bclk_sync_r <= {bclk_sync_r[1:0], bit_clk_i};
      fs_sync_r <= {fs_sync_r[1:0], frame_sync_i};
      shdn_n_r <= filt(shdn_sync_r, shdn_n_r);
      bclk_r <= filt(bclk_sync_r, bclk_r);
      fs_r <= filt(fs_sync_r, fs_r);
    end
  end

  logic bclk_now;
  logic fs_now;
  logic bclk_rise;
  logic bclk_fall;
  logic fs_at_rise_r;
  logic fs_rise_r;
  assign bclk_now = filt(bclk_sync_r, bclk_r);
  assign fs_now = filt(fs_sync_r, fs_r);
  assign bclk_rise = bclk_now && !bclk_r;
  assign bclk_fall = !bclk_now && bclk_r;

  // frame sync sampled on bit clock rising edge, frame start launched on next fall
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fs_at_rise_r <= 1'b0;
      fs_rise_r <= 1'b0;
    end else if (bclk_rise) begin
      fs_at_rise_r <= fs_now;
      fs_rise_r <= fs_now && !fs_at_rise_r;
    end else if (bclk_fall) begin
      fs_rise_r <= 1'b0;
    end
  end

  // ==========================================================================
  // clock activity watchdog: link counted as clocked while bit clock toggles
  logic [6:0] idle_cnt_r;
  logic clocked;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt_r <= 7'(BCLK_IDLE_CYC);
    end else if (bclk_rise) begin
      idle_cnt_r <= 7'h00;
    end else if (idle_cnt_r != 7'(BCLK_IDLE_CYC)) begin
      idle_cnt_r <= idle_cnt_r + 7'h01;
    end
  end
  assign clocked = idle_cnt_r != 7'(BCLK_IDLE_CYC);

  // ==========================================================================
  // register file
  cfg_s cfg_r;
  logic [7:0] ch_src_r [SLOTS];
  pwr_state_e state_r;
  logic writable;
  assign writable = shdn_n_r && state_r != ST_HW_SHDN && state_r != ST_INIT;

  function automatic int src_slot(input logic [7:0] idx);
    case (idx)
      CH1_SRC_IDX: return 0;
      CH2_SRC_IDX: return 1;
      CH3_SRC_IDX: return 2;
      CH4_SRC_IDX: return 3;
      default: return -1;
    endcase
  endfunction : src_slot

  // registers return to defaults only through shutdown; sleep leaves them alone
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_r <= '{SLEEP_CTRL_RST, IN_CH_EN_RST, OUT_SLOT_EN_RST, PWR_UP_RST};
      for (int i = 0; i < SLOTS; i++) ch_src_r[i] <= CH_SRC_RST;
    end else if (state_r == ST_HW_SHDN) begin
      cfg_r <= '{SLEEP_CTRL_RST, IN_CH_EN_RST, OUT_SLOT_EN_RST, PWR_UP_RST};
      for (int i = 0; i < SLOTS; i++) ch_src_r[i] <= CH_SRC_RST;
    end else if (reg_wr_i.we && writable) begin
      case (reg_wr_i.idx)
        SLEEP_CTRL_IDX: cfg_r.sleep_ctrl <= reg_wr_i.data;
        IN_CH_EN_IDX: cfg_r.in_ch_en <= reg_wr_i.data;
        OUT_SLOT_EN_IDX: cfg_r.out_slot_en <= reg_wr_i.data;
        PWR_UP_IDX: cfg_r.pwr_up <= reg_wr_i.data;
        default: begin
          if (src_slot(reg_wr_i.idx) >= 0) begin
            ch_src_r[2'(src_slot(reg_wr_i.idx))] <= reg_wr_i.data;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // power-mode state machine
  logic [31:0] wait_cnt_r;
  logic asleep;
  // bit 0 high means awake: the wake value 0x81 sets it, 0x80 puts the part to sleep
  assign asleep = !cfg_r.sleep_ctrl[SLEEP_BIT];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_HW_SHDN;
      wait_cnt_r <= 32'h0;
    end else if (!shdn_n_r) begin
      state_r <= ST_HW_SHDN;
      wait_cnt_r <= 32'h0;
    end else begin
      case (state_r)
        ST_HW_SHDN: begin
          state_r <= ST_INIT;
          wait_cnt_r <= 32'(INIT_CYC);
        end
        ST_INIT: begin
          if (wait_cnt_r <= 32'h1) state_r <= ST_SLEEP;
          else wait_cnt_r <= wait_cnt_r - 32'h1;
        end
        ST_SLEEP: begin
          if (!asleep) begin
            state_r <= ST_WAKING;
            wait_cnt_r <= 32'(WAKE_CYC);
          end
        end
        ST_WAKING: begin
          if (asleep) begin
            state_r <= ST_RAMP_DN;
            wait_cnt_r <= 32'(RAMP_CYC);
          end else if (wait_cnt_r <= 32'h1) begin
            state_r <= ST_ACTIVE;
          end else begin
            wait_cnt_r <= wait_cnt_r - 32'h1;
          end
        end
        ST_ACTIVE: begin
          if (asleep) begin
            state_r <= ST_RAMP_DN;
            wait_cnt_r <= 32'(RAMP_CYC);
          end
        end
        ST_RAMP_DN: begin
          if (wait_cnt_r <= 32'h1) state_r <= ST_SLEEP;
          else wait_cnt_r <= wait_cnt_r - 32'h1;
        end
        default: state_r <= ST_HW_SHDN;
      endcase
    end
  end

  // ==========================================================================
  // outputs and read-back
  logic stream_run;
  assign stream_run = state_r == ST_ACTIVE && cfg_r.pwr_up[ADC_PWR_BIT] && clocked;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_o <= ST_HW_SHDN;
      sleep_status_o <= 1'b0;
      mic_bias_en_o <= 1'b0;
      internal_regulator_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      state_o <= state_r;
      sleep_status_o <= state_r == ST_SLEEP;
      mic_bias_en_o <= state_r == ST_ACTIVE && cfg_r.pwr_up[BIAS_PWR_BIT];
      internal_regulator_o <= state_r != ST_HW_SHDN && cfg_r.sleep_ctrl[REGULATOR_BIT];
      case (rd_idx_i)
        SLEEP_CTRL_IDX: rd_data_o <= cfg_r.sleep_ctrl;
        IN_CH_EN_IDX: rd_data_o <= cfg_r.in_ch_en;
        OUT_SLOT_EN_IDX: rd_data_o <= cfg_r.out_slot_en;
        PWR_UP_IDX: rd_data_o <= cfg_r.pwr_up;
        DEV_STATUS_IDX: rd_data_o <= {state_r == ST_SLEEP, 7'h00};
        default: begin
          if (src_slot(rd_idx_i) >= 0) rd_data_o <= ch_src_r[2'(src_slot(rd_idx_i))];
          else rd_data_o <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // tdm transmitter, slot enables gated by input channel enables
  logic [SLOTS-1:0] slot_en;
  assign slot_en = cfg_r.out_slot_en[7 -: SLOTS] & cfg_r.in_ch_en[7 -: SLOTS];
  logic [SLOTS-1:0] slot_en_rev;
  always_comb begin
    slot_en_rev = '0;
    for (int i = 0; i < SLOTS; i++) slot_en_rev[i] = slot_en[SLOTS-1-i];
  end

  tdm_tx #(.W(WORD_BITS), .N(SLOTS)) u_tx (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .run_i(stream_run),
    .bclk_fall_i(bclk_fall),
    .fs_rise_i(fs_rise_r),
    .slot_en_i(slot_en_rev),
    .samples_i(samples_i),
    .sdout_o(sdout_o)
  );

endmodule : adc_power_mode_sequencer

// ---- host_link_model.sv ----
// host side of the serial link: bit clock and one-bit frame sync
// assumes run_i is driven by the bench; clocks stand still between frames only while run_i is low
`timescale 1ns/100ps
module host_link_model #(
  parameter int BCLK_PER_FS = 256
) (
  input wire logic run_i, // supply clocks
  output logic bit_clk_o, // bit clock, 48 ns
  output logic frame_sync_o // frame sync
);
  // ==========================================================================
  // whole frames only, phase offset from the system clock
  initial begin
    bit_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    #1.3;
    forever begin
      wait (run_i);
      for (int b = 0; b < BCLK_PER_FS; b++) begin
        frame_sync_o = (b == 0);
        #24 bit_clk_o = 1'b1;
        #24 bit_clk_o = 1'b0;
      end
    end
  end
endmodule : host_link_model

// ---- pwr_seq_checker.sv ----
// checker of the power-mode sequencer seen from its top ports
// assumes a bind from the bench onto adc_power_mode_sequencer
`timescale 1ns/100ps
module pwr_seq_checker
  import pwr_seq_pkg::*;
#(
  parameter int INIT_CYC = 20,
  parameter int WAKE_CYC = 20,
  parameter int RAMP_CYC = 40
) (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic hw_shutdown_pin_n_i, // shutdown pin
  input wire reg_wr_s reg_wr_i, // register write
  input wire logic sdout_o, // serial data
  input wire pwr_state_e state_o, // power mode
  input wire logic sleep_status_o // asleep flag
);
  // ==========================================================================
  // dwell counter: cycles spent in the mode just left
  logic [31:0] dwell_r;
  pwr_state_e prev_r;
  logic wr02;
  assign wr02 = reg_wr_i.we && reg_wr_i.idx == SLEEP_CTRL_IDX;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= ST_HW_SHDN;
      dwell_r <= '0;
    end else begin
      prev_r <= state_o;
      dwell_r <= (state_o != prev_r) ? 32'h1 : dwell_r + 32'h1;
    end
  end
  // ==========================================================================
  // assertions
  a_pin_low_shdn: assert property (!hw_shutdown_pin_n_i [*7] |-> state_o == ST_HW_SHDN)
    else $error("mode not shutdown with pin low");
  a_shdn_exit_init: assert property ($past(state_o) == ST_HW_SHDN |-> state_o inside {ST_HW_SHDN, ST_INIT})
    else $error("shutdown left without init");
  a_init_dwell_ok: assert property ($past(state_o) == ST_INIT && state_o == ST_SLEEP |-> dwell_r inside {[INIT_CYC-2:INIT_CYC+3]})
    else $error("init time wrong");
  a_wake_dwell_ok: assert property ($past(state_o) == ST_WAKING && state_o == ST_ACTIVE |-> dwell_r inside {[WAKE_CYC-2:WAKE_CYC+3]})
    else $error("wake time wrong");
  a_ramp_dwell_ok: assert property ($past(state_o) == ST_RAMP_DN && state_o == ST_SLEEP |-> dwell_r inside {[RAMP_CYC-2:RAMP_CYC+3]})
    else $error("ramp time wrong");
  a_wake_cmd_taken: assert property (wr02 && reg_wr_i.data == 8'h81 && state_o == ST_SLEEP |-> ##[1:3] state_o == ST_WAKING)
    else $error("wake write not taken");
  a_sleep_cmd_taken: assert property (wr02 && !reg_wr_i.data[SLEEP_BIT] && state_o == ST_ACTIVE |-> ##[1:3] state_o == ST_RAMP_DN)
    else $error("sleep write not taken");
  a_status_in_sleep: assert property ((state_o == ST_SLEEP) [*2] |-> sleep_status_o)
    else $error("status low in sleep");
  a_quiet_unless_on: assert property ((state_o != ST_ACTIVE) [*4] |-> !sdout_o)
    else $error("data sent while not active");
endmodule : pwr_seq_checker

// ---- pwr_seq_pkg.sv ----
// holds the shared constants and carriers of the power-mode sequencer
// assumes a 200 MHz system clock and register writes already decoded by a control front end
package pwr_seq_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 200;
  localparam int INIT_WAIT_US = 1000;
  localparam int WAKE_WAIT_US = 1000;
  localparam int SLEEP_RAMP_US = 6000;
  localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
  localparam int WAKE_WAIT_CYC = WAKE_WAIT_US * CLK_MHZ;
  localparam int SLEEP_RAMP_CYC = SLEEP_RAMP_US * CLK_MHZ;
  // link counts as clocked while a bit clock rise came within this many cycles
  localparam int BCLK_IDLE_CYC = 64;

  // ==========================================================================
  // register indices
  localparam logic [7:0] SLEEP_CTRL_IDX = 8'h02;
  localparam logic [7:0] CH1_SRC_IDX = 8'h3C;
  localparam logic [7:0] CH2_SRC_IDX = 8'h41;
  localparam logic [7:0] CH3_SRC_IDX = 8'h46;
  localparam logic [7:0] CH4_SRC_IDX = 8'h4B;
  localparam logic [7:0] IN_CH_EN_IDX = 8'h73;
  localparam logic [7:0] OUT_SLOT_EN_IDX = 8'h74;
  localparam logic [7:0] PWR_UP_IDX = 8'h75;
  localparam logic [7:0] DEV_STATUS_IDX = 8'h77;

  // ==========================================================================
  // fields and reset values
  localparam int SLEEP_BIT = 0;
  // sleep control bit 0 high keeps the device awake, so reset leaves it asleep
  localparam int REGULATOR_BIT = 7;
  localparam int STATUS_SLEEP_BIT = 7;
  localparam int ADC_PWR_BIT = 7;
  localparam int BIAS_PWR_BIT = 6;
  localparam logic [7:0] SLEEP_CTRL_RST = 8'h00;
  localparam logic [7:0] IN_CH_EN_RST = 8'h00;
  localparam logic [7:0] OUT_SLOT_EN_RST = 8'h00;
  localparam logic [7:0] PWR_UP_RST = 8'h00;
  localparam logic [7:0] CH_SRC_RST = 8'h00;
  localparam int WORD_BITS = 32;
  localparam int SLOTS = 4;

  typedef enum logic [2:0] {
    ST_HW_SHDN = 3'b000,
    ST_INIT = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKING = 3'b011,
    ST_ACTIVE = 3'b100,
    ST_RAMP_DN = 3'b101
  } pwr_state_e;

  typedef struct packed {
    logic       we;
    logic [7:0] idx;
    logic [7:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic [7:0] sleep_ctrl;
    logic [7:0] in_ch_en;
    logic [7:0] out_slot_en;
    logic [7:0] pwr_up;
  } cfg_s;

endpackage : pwr_seq_pkg

// ---- tb.sv ----
// self-checking bench of the power-mode sequencer
// assumes shortened waits 20/20/40 cycles and the host link model
`timescale 1ns/100ps
module tb;
  import pwr_seq_pkg::*;
  logic clk_i;
  logic rstn_i;
  logic pin_n;
  logic run;
  logic bclk;
  logic fs;
  reg_wr_s wr;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;
  logic sdout;
  logic sleep_st;
  logic bias;
  logic regulator;
  pwr_state_e state;
  logic [127:0] smp = 128'h89ABCDEF_01234567_F00DCAFE_A5C3E187;
  logic [7:0] cfg_idx [5] = '{8'h3C, 8'h46, 8'h73, 8'h74, 8'h75};
  logic [7:0] cfg_dat [5] = '{8'h00, 8'h00, 8'hF0, 8'hF0, 8'hE0};
  int n_errors = 0;
  int check_count = 0;
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  adc_power_mode_sequencer #(.INIT_CYC(20), .WAKE_CYC(20), .RAMP_CYC(40)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .hw_shutdown_pin_n_i(pin_n), .bit_clk_i(bclk),
    .frame_sync_i(fs), .reg_wr_i(wr), .rd_idx_i(rd_idx), .samples_i(smp),
    .rd_data_o(rd_data), .sdout_o(sdout), .state_o(state), .sleep_status_o(sleep_st),
    .mic_bias_en_o(bias), .internal_regulator_o(regulator));
  host_link_model host (.run_i(run), .bit_clk_o(bclk), .frame_sync_o(fs));
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_i);
    wr = '{1'b1, i, d};
    @(negedge clk_i);
    wr.we = 1'b0;
  endtask : wr_reg
  task automatic rd(input logic [7:0] i);
    @(negedge clk_i);
    rd_idx = i;
    repeat (2) @(negedge clk_i);
  endtask : rd
  task automatic wait_st(input pwr_state_e s, input int lim, output int n);
    n = 0;
    while (state !== s && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk(64'(state), 64'(s));
  endtask : wait_st
  task automatic stream_chk;
    logic [63:0] got;
    got = '0;
    repeat (2) @(posedge bclk iff fs === 1'b1);
    @(negedge bclk);
    repeat (64) begin
      @(negedge bclk);
      got = {got[62:0], sdout};
    end
    chk(got, {smp[31:0], smp[63:32]});
  endtask : stream_chk
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================================
  // scenarios
  task automatic t_shutdown;
    repeat (10) @(negedge clk_i);
    wr_reg(SLEEP_CTRL_IDX, 8'h81);
    repeat (5) @(negedge clk_i);
    chk(64'(state), 64'(ST_HW_SHDN));
  endtask : t_shutdown
  task automatic t_bringup;
    int n;
    pin_n = 1'b1;
    wait_st(ST_INIT, 10, n);
    wait_st(ST_SLEEP, 40, n);
    chk(64'(n >= 18 && n <= 23), 64'h1);
    chk(64'(sleep_st), 64'h1);
    rd(DEV_STATUS_IDX);
    chk(64'(rd_data[7]), 64'h1);
  endtask : t_bringup
  task automatic t_wake;
    int n;
    wr_reg(SLEEP_CTRL_IDX, 8'h81);
    wait_st(ST_ACTIVE, 40, n);
    chk(64'({regulator, sleep_st}), 64'h2);
  endtask : t_wake
  task automatic t_config;
    for (int k = 0; k < 5; k++) wr_reg(cfg_idx[k], cfg_dat[k]);
    rd(IN_CH_EN_IDX);
    chk(64'(rd_data), 64'hF0);
    chk(64'(bias), 64'h1);
  endtask : t_config
  task automatic t_sleep;
    int n;
    int k;
    wr_reg(SLEEP_CTRL_IDX, 8'h80);
    wait_st(ST_RAMP_DN, 5, n);
    k = 0;
    do begin
      rd(DEV_STATUS_IDX);
      k++;
    end while (rd_data[7] !== 1'b1 && k < 60);
    // three cycles per poll against the 40-cycle ramp: status shows on poll 14
    chk(64'(k >= 13 && k <= 14), 64'h1);
    chk(64'(rd_data[7]), 64'h1);
    run = 1'b0;
    rd(OUT_SLOT_EN_IDX);
    chk(64'(rd_data), 64'hF0);
  endtask : t_sleep
  task automatic t_hwshdn;
    int n;
    pin_n = 1'b0;
    wait_st(ST_HW_SHDN, 10, n);
    run = 1'b0;
    rd(IN_CH_EN_IDX);
    chk(64'(rd_data), 64'h00);
    pin_n = 1'b1;
    wait_st(ST_SLEEP, 40, n);
  endtask : t_hwshdn
  initial begin
    rstn_i = 1'b0;
    pin_n = 1'b0;
    run = 1'b0;
    wr = '0;
    rd_idx = '0;
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    t_shutdown;
    t_bringup;
    t_wake;
    t_config;
    run = 1'b1;
    stream_chk;
    t_sleep;
    t_wake;
    run = 1'b1;
    stream_chk;
    t_hwshdn;
    end_of_test;
  end
  initial begin
    #400000;
    n_errors++;
    end_of_test;
  end
endmodule : tb
bind adc_power_mode_sequencer pwr_seq_checker #(.INIT_CYC(INIT_CYC), .WAKE_CYC(WAKE_CYC),
  .RAMP_CYC(RAMP_CYC)) chk_u (.clk_i(clk_i), .rstn_i(rstn_i),
  .hw_shutdown_pin_n_i(hw_shutdown_pin_n_i), .reg_wr_i(reg_wr_i), .sdout_o(sdout_o),
  .state_o(state_o), .sleep_status_o(sleep_status_o));

// ---- tdm_tx.sv ----
// holds the tdm target transmitter: shifts channel words out on bit clock edges
// assumes bit clock and frame sync already synchronised and edge-detected by the caller
`timescale 1ns/100ps
module tdm_tx
  import pwr_seq_pkg::*;
#(
  parameter int W = WORD_BITS,
  parameter int N = SLOTS
) (
  input wire logic clk_i, // system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic run_i, // stream enabled
  input wire logic bclk_fall_i, // bit clock falling edge pulse
  input wire logic fs_rise_i, // frame sync rising edge, sampled on bit clock edge
  input wire logic [N-1:0] slot_en_i, // output slot enables
  input wire logic [N*W-1:0] samples_i, // channel samples, channel 1 in low word
  output logic sdout_o // serial data
);

  logic [W-1:0] shreg_r;
  logic [7:0] bitcnt_r;
  logic [3:0] slot_r;
  logic [3:0] slot_nxt;

  // a frame start restarts at slot 0, otherwise step to the next slot
  assign slot_nxt = fs_rise_i ? 4'h0 : slot_r + 4'h1;

  // ==========================================================================
  // shifter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shreg_r <= '0;
      bitcnt_r <= 8'h00;
      slot_r <= 4'h0;
      sdout_o <= 1'b0;
    end else if (!run_i) begin
      sdout_o <= 1'b0;
      slot_r <= 4'h0;
      bitcnt_r <= 8'h00;
    end else if (bclk_fall_i) begin
      if (fs_rise_i || bitcnt_r == 8'(W - 1)) begin
        slot_r <= slot_nxt;
        bitcnt_r <= 8'h00;
        if (slot_nxt < 4'(N) && slot_en_i[slot_nxt[1:0]]) begin
          shreg_r <= {samples_i[slot_nxt[1:0]*W +: W-1], 1'b0};
          sdout_o <= samples_i[slot_nxt[1:0]*W + W - 1];
        end else begin
          shreg_r <= '0;
          sdout_o <= 1'b0;
        end
      end else begin
        bitcnt_r <= bitcnt_r + 8'h01;
        sdout_o <= shreg_r[W-1];
        shreg_r <= {shreg_r[W-2:0], 1'b0};
      end
    end
  end

endmodule : tdm_tx
